/* File: rtl/access_monitor_pkg.sv */
// Constants for the forbidden-access reset monitor: register map, field
// positions, reset values and the address regions of the access map.
// Assumes a 20-bit CPU address space and a 32-bit AHB-Lite register bus.
package access_monitor_pkg;

    // ==========================================================
    // Register map
    localparam logic [31:0] ACCESS_MONITOR_CONTROL_ADDR = 32'h000F0078;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h000F0080;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h000F0084;
    localparam logic [31:0] MONITOR_STATE_ADDR = 32'h000F0088;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WRITABLE = 8'hB7;
    localparam int DETECT_ON_BIT = 7;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam int IRQ_VIOLATION_BIT = 0;
    localparam int IRQ_BLOCKED_CLEAR_BIT = 1;

    // ==========================================================
    // Access map
    localparam int ADDR_W = 20;
    localparam logic [19:0] SFR_LO = 20'hFFF00;
    localparam logic [19:0] SFR_HI = 20'hFFFFF;
    localparam logic [19:0] RSV_HIGH_LO = 20'hF8000;
    localparam logic [19:0] RSV_HIGH_HI = 20'hFDEFF;
    localparam logic [19:0] MIRROR_LO = 20'hF2000;
    localparam logic [19:0] MIRROR_HI = 20'hF7FFF;
    localparam logic [19:0] SFR2_LO = 20'hF0000;
    localparam logic [19:0] SFR2_HI = 20'hF07FF;
    localparam logic [19:0] RSV_LOW_LO = 20'h10000;
    localparam logic [19:0] RSV_LOW_HI = 20'hEEFFF;
    localparam logic [19:0] CODE_HI = 20'h07FFF;

    // Kind of CPU access.
    typedef enum logic [1:0] {
        ACC_FETCH = 2'b00,
        ACC_READ = 2'b01,
        ACC_WRITE = 2'b11
    } access_kind_e;

endpackage

/* File: rtl/access_map_check.sv */
// Combinational classifier of one CPU access against the access map.
// Assumes address and kind are stable in the cycle the access is issued.
`timescale 1ns/1ns
`default_nettype none
module access_map_check (
    // Access
    input wire logic [access_monitor_pkg::ADDR_W-1:0] addr,
    input wire logic [1:0] kind,
    // Verdict
    output logic forbidden
);
    import access_monitor_pkg::*;

    function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo,
                                      input logic [19:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    logic is_fetch;
    logic is_write;

    always_comb begin
        is_fetch = (kind == ACC_FETCH);
        is_write = (kind == ACC_WRITE);
        forbidden = 1'b0;
        if (in_range(addr, SFR_LO, SFR_HI) && is_fetch) begin
            forbidden = 1'b1; // RL7
        end
        if (in_range(addr, RSV_HIGH_LO, RSV_HIGH_HI)) begin
            forbidden = 1'b1; // RL8
        end
        if (in_range(addr, MIRROR_LO, MIRROR_HI) && (is_fetch || is_write)) begin
            forbidden = 1'b1; // RL9
        end
        if (in_range(addr, SFR2_LO, SFR2_HI) && is_fetch) begin
            forbidden = 1'b1; // RL10
        end
        if (in_range(addr, RSV_LOW_LO, RSV_LOW_HI)) begin
            forbidden = 1'b1; // RL11
        end
        // Code storage fetches and reads stay allowed; everything else not
        // listed above is allowed too, so no spurious reset is raised.
        if (addr <= CODE_HI && !is_write) begin
            forbidden = 1'b0; // RL12 RL14
        end
    end

endmodule
`default_nettype wire

/* File: rtl/access_monitor.sv */
// Forbidden-access reset monitor with its AHB-Lite control registers.
// Assumes the CPU access port and the option strap are in the hclk domain.
//
// What this block does
// RL1: While detection is active, a forbidden CPU access requests an internal reset.
// RL2: Control bit 7 enables detection of forbidden accesses.
// RL3: Detection enable is set-only; writing zero never clears it before reset.
// RL4: Watchdog option at one forces detection on regardless of the bit.
// RL5: Any reset returns the control register to zero.
// RL6: Software updates the control register only with byte-wide writes; the block takes hwdata[7:0] from a write of any hsize.
// RL7: Fetch from the top 256-byte register window is forbidden.
// RL8: Any access to F8000 through FDEFF is forbidden.
// RL9: Fetches and writes in the mirror F2000 through F7FFF are forbidden.
// RL10: Fetch from the extended register window F0000 through F07FF is forbidden.
// RL11: Any access to 10000 through EEFFF is forbidden.
// RL12: Fetches and reads in code storage up to 07FFF are allowed.
// RL13: Classify each access in its issue cycle; reset request is one-cycle pulse.
// RL14: Regions with unknown permissions are treated as allowed.
`timescale 1ns/1ns
`default_nettype none
module access_monitor (
    // Clock, reset and enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // CPU access port
    input wire logic cpu_valid,
    input wire logic [access_monitor_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic [1:0] cpu_kind,
    // Option strap
    input wire logic watchdog_run_option,
    // Results
    output logic reset_request,
    output logic irq,
    output logic [7:0] access_monitor_control_out
);
    import access_monitor_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] access_monitor_control;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic dp_write;
        logic [31:0] dp_addr;
        logic [31:0] hrdata;
        logic reset_request;
        logic irq;
        logic [19:0] last_addr;
        logic [1:0] last_kind;
    } state_s;

    state_s r;
    state_s next_r;

    logic forbidden;
    logic opt_meta;
    logic opt_sync;
    logic detect_active;
    logic addr_phase;
    logic [7:0] wbyte;
    logic [1:0] events;

    // ==========================================================
    // Option strap synchroniser
    // The strap is a pin; only the second stage feeds any logic.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opt_meta <= 1'b0;
            opt_sync <= 1'b0;
        end else if (clk_en) begin
            opt_meta <= watchdog_run_option;
            opt_sync <= opt_meta;
        end
    end

    access_map_check u_map (
        .addr(cpu_addr),
        .kind(cpu_kind),
        .forbidden(forbidden)
    );

    function automatic logic [31:0] read_mux(input state_s s, input logic [31:0] a,
                                             input logic opt);
        read_mux = 32'h00000000;
        unique case (a)
            ACCESS_MONITOR_CONTROL_ADDR: read_mux = {24'h000000, s.access_monitor_control};
            IRQ_STATUS_ADDR: read_mux = {30'h00000000, s.irq_status};
            IRQ_MASK_ADDR: read_mux = {30'h00000000, s.irq_mask};
            MONITOR_STATE_ADDR: read_mux = {9'h000, opt, s.last_kind, s.last_addr};
            default: read_mux = 32'h00000000;
        endcase
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_r = r;
        detect_active = r.access_monitor_control[DETECT_ON_BIT] || opt_sync; // RL2 RL4
        addr_phase = hsel && hready && htrans[1];
        wbyte = hwdata[7:0];
        events = 2'h0;

        next_r.reset_request = 1'b0;
        if (cpu_valid && forbidden && detect_active) begin
            next_r.reset_request = 1'b1; // RL1 RL13
            next_r.last_addr = cpu_addr;
            next_r.last_kind = cpu_kind;
            events[IRQ_VIOLATION_BIT] = 1'b1;
        end

        // Data phase of a write captured in the previous cycle.
        if (r.dp_write) begin
            unique case (r.dp_addr)
                ACCESS_MONITOR_CONTROL_ADDR: begin
                    // Byte-wide update of the writable fields; the enable only sets.
                    next_r.access_monitor_control = (wbyte & CONTROL_WRITABLE)
                        | (r.access_monitor_control & 8'h80); // RL3 RL6
                    if (!wbyte[DETECT_ON_BIT] && r.access_monitor_control[DETECT_ON_BIT]) begin
                        events[IRQ_BLOCKED_CLEAR_BIT] = 1'b1;
                    end
                end
                IRQ_STATUS_ADDR: next_r.irq_status = r.irq_status & ~hwdata[1:0];
                IRQ_MASK_ADDR: next_r.irq_mask = hwdata[1:0];
                default: next_r.irq_mask = next_r.irq_mask;
            endcase
        end
        // A new event wins over a write-one-to-clear in the same cycle.
        next_r.irq_status = next_r.irq_status | events;
        next_r.irq = |(next_r.irq_status & next_r.irq_mask);

        next_r.dp_write = addr_phase && hwrite;
        if (addr_phase) begin
            next_r.dp_addr = haddr;
            next_r.hrdata = read_mux(r, haddr, opt_sync);
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r.access_monitor_control <= CONTROL_RESET; // RL5
            r.irq_status <= IRQ_RESET;
            r.irq_mask <= IRQ_RESET;
            r.dp_write <= 1'b0;
            r.dp_addr <= 32'h00000000;
            r.hrdata <= 32'h00000000;
            r.reset_request <= 1'b0;
            r.irq <= 1'b0;
            r.last_addr <= 20'h00000;
            r.last_kind <= 2'h0;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign hrdata = r.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign reset_request = r.reset_request;
    assign irq = r.irq;
    assign access_monitor_control_out = r.access_monitor_control;

endmodule
`default_nettype wire

/* File: sim/access_monitor_chk.sv */
// Concurrent checks of the access monitor at its own ports.
// Assumes one clock domain; bound by the statement at the foot.
`timescale 1ns/1ns
`default_nettype none
module access_monitor_chk (
    // Clock and controls
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic watchdog_run_option,
    // CPU access port
    input wire logic cpu_valid,
    input wire logic [19:0] cpu_addr,
    input wire logic [1:0] cpu_kind,
    // Results
    input wire logic reset_request,
    input wire logic [7:0] access_monitor_control_out
);
    // ==========================================================
    // Access map, strap, enable and reset properties
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic v;
    logic on;
    assign v = cpu_valid && clk_en;
    assign on = access_monitor_control_out[7];
    // The strap crosses two synchroniser stages, so it must be held three cycles.
    sequence s_strap_held;
        (clk_en && watchdog_run_option)[*3];
    endsequence
    sequence s_strap_low;
        (!watchdog_run_option)[*3];
    endsequence
    chk_pulse_src: assert property (reset_request |-> $past(cpu_valid) || !$past(clk_en))
        else $error("reset request without an access");
    chk_always_bad: assert property (v && on && cpu_addr inside
        {[20'h10000:20'hEEFFF], [20'hF8000:20'hFDEFF]} |=> reset_request)
        else $error("reserved access not caught");
    chk_mirror_guard: assert property (v && on && cpu_kind inside {2'h0, 2'h3}
        && cpu_addr inside {[20'hF2000:20'hF7FFF]} |=> reset_request)
        else $error("mirror fetch or write not caught");
    chk_sfr_fetch: assert property (v && on && cpu_kind == 2'h0 && cpu_addr >= 20'hFFF00
        |=> reset_request)
        else $error("register window fetch not caught");
    chk_off_quiet: assert property (s_strap_low ##0 (v && !on) |=> !reset_request)
        else $error("reset request while detection off");
    chk_strap_force: assert property (s_strap_held ##0 (v && cpu_addr inside
        {[20'h10000:20'hEEFFF], [20'hF8000:20'hFDEFF]}) |=> reset_request)
        else $error("strap did not force detection");
    chk_enable_sticky: assert property (on |=> on)
        else $error("detection enable cleared");
    chk_reset_clear: assert property ($rose(hresetn) |-> access_monitor_control_out == 8'h00)
        else $error("control not zero after reset");
endmodule
bind access_monitor access_monitor_chk u_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .watchdog_run_option(watchdog_run_option), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr),
    .cpu_kind(cpu_kind), .reset_request(reset_request),
    .access_monitor_control_out(access_monitor_control_out));
`default_nettype wire

/* File: sim/cpu_access_model.sv */
// Behavioural CPU issuing one fetch, read or write per call of issue.
// Assumes hclk is the monitor's clock.
`timescale 1ns/1ns
`default_nettype none
module cpu_access_model (
    // Clock
    input wire logic hclk,
    // Access port
    output logic cpu_valid,
    output logic [19:0] cpu_addr,
    output logic [1:0] cpu_kind
);
    // ==========================================================
    // Access issue
    initial begin
        cpu_valid = 1'b0;
        cpu_addr = 20'h00000;
        cpu_kind = 2'h0;
    end
    task automatic issue(input logic [19:0] a, input logic [1:0] k);
        @(posedge hclk);
        cpu_valid <= 1'b1;
        cpu_addr <= a;
        cpu_kind <= k;
        @(posedge hclk);
        // Idle lines show the inverse, so a stale address never looks current.
        cpu_valid <= 1'b0;
        cpu_addr <= ~a;
        cpu_kind <= ~k;
    endtask
endmodule
`default_nettype wire

/* File: sim/illegal_access_reset_monitor_tb_top.sv */
// Bench of the access monitor: bus, access map, interrupt, strap and reset.
// Assumes the CPU model drives the access port and the checker is bound.
`timescale 1ns/1ns
`default_nettype none
module illegal_access_reset_monitor_tb_top;
    import access_monitor_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic watchdog_run_option = 1'b0;
    logic clk_en = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, r;
    logic hreadyout, hresp, cpu_valid, reset_request, irq;
    logic [19:0] cpu_addr;
    logic [1:0] cpu_kind;
    logic [7:0] ctrl;
    int miscompares = 0;
    int n_checks = 0;
    always #2 hclk = ~hclk;
    access_monitor dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .cpu_kind(cpu_kind), .irq(irq),
        .watchdog_run_option(watchdog_run_option), .reset_request(reset_request),
        .access_monitor_control_out(ctrl));
    cpu_access_model cpu (.hclk(hclk), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr),
        .cpu_kind(cpu_kind));
    // ==========================================================
    // Shared tasks
    task automatic final_report();
        if (miscompares == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic hold();
        for (int n = 0; n < 20; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        miscompares++;
        final_report();
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hold();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        hold();
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
        #1;
    endtask
    task automatic acc(input logic [19:0] a, input logic [1:0] k, input logic exp);
        cpu.issue(a, k);
        #1;
        chk({31'h0, reset_request}, {31'h0, exp});
        @(posedge hclk);
        #1;
        chk({31'h0, reset_request}, 32'h0);
    endtask
    function automatic logic bad(input logic [19:0] a, input logic [1:0] k);
        return (k == 2'h0 && (a >= 20'hFFF00 || a inside {[20'hF0000:20'hF07FF]}))
            || a inside {[20'h10000:20'hEEFFF], [20'hF8000:20'hFDEFF]}
            || (k != 2'h1 && a inside {[20'hF2000:20'hF7FFF]});
    endfunction
    // ==========================================================
    // Scenarios
    task automatic t_reset_off();
        bus(1'b0, ACCESS_MONITOR_CONTROL_ADDR, 32'h0);
        chk(r, 32'h0);
        acc(20'h10000, 2'h1, 1'b0);
    endtask
    task automatic t_enable_irq();
        bus(1'b1, ACCESS_MONITOR_CONTROL_ADDR, 32'h80);
        bus(1'b1, IRQ_MASK_ADDR, 32'h1);
        acc(20'h20000, 2'h3, 1'b1);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, MONITOR_STATE_ADDR, 32'h0);
        chk(r, 32'h00320000);
        bus(1'b1, IRQ_MASK_ADDR, 32'h0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, IRQ_MASK_ADDR, 32'h1);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, IRQ_STATUS_ADDR, 32'h3);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, IRQ_MASK_ADDR, 32'h0);
    endtask
    task automatic t_sticky();
        bus(1'b1, ACCESS_MONITOR_CONTROL_ADDR, 32'h7F);
        bus(1'b0, ACCESS_MONITOR_CONTROL_ADDR, 32'h0);
        chk(r, {24'h0, CONTROL_WRITABLE});
        bus(1'b0, IRQ_STATUS_ADDR, 32'h0);
        chk(r, 32'h2);
        bus(1'b0, 32'h000F0090, 32'h0);
        chk(r, 32'h0);
    endtask
    task automatic t_map();
        logic [19:0] am [17] = '{20'h00000, 20'h07FFF, 20'h08000, 20'h10000, 20'hEEFFF,
            20'hEF000, 20'hF0000, 20'hF07FF, 20'hF0800, 20'hF2000, 20'hF7FFF, 20'hF8000,
            20'hFDEFF, 20'hFDF00, 20'hFFEFF, 20'hFFF00, 20'hFFFFF};
        logic [1:0] km [3] = '{2'h0, 2'h1, 2'h3};
        foreach (am[i]) begin
            foreach (km[j]) begin
                acc(am[i], km[j], bad(am[i], km[j]));
            end
        end
    endtask
    task automatic t_freeze();
        // A frozen monitor must neither see the access nor pulse later.
        @(posedge hclk);
        clk_en <= 1'b0;
        acc(20'h10000, 2'h1, 1'b0);
        @(posedge hclk);
        clk_en <= 1'b1;
        acc(20'h10000, 2'h1, 1'b1);
    endtask
    task automatic t_strap();
        @(posedge hclk);
        hresetn <= 1'b0;
        watchdog_run_option <= 1'b1;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, ACCESS_MONITOR_CONTROL_ADDR, 32'h0);
        chk(r, 32'h0);
        acc(20'hF8000, 2'h1, 1'b1);
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_off();
        t_enable_irq();
        t_sticky();
        t_map();
        t_freeze();
        t_strap();
        final_report();
    end
endmodule
`default_nettype wire
